// file: core/ser_pkg.sv
// Purpose: Shared constants and types for the status event reporting block
// Assumes: 32-bit APB data, one word per register
// Notes: Condition groups are 16 bits wide, status byte is 8 bits
package ser_pkg;
  localparam int unsigned GRP_W = 16;
  // Register byte offsets
  localparam logic [7:0] OFF_OPERATION_SUMMARY_COND = 8'h00;
  localparam logic [7:0] OFF_OPERATION_SUMMARY_PTR = 8'h04;
  localparam logic [7:0] OFF_OPERATION_SUMMARY_NTR = 8'h08;
  localparam logic [7:0] OFF_OPERATION_SUMMARY_EVENT = 8'h0c;
  localparam logic [7:0] OFF_OPERATION_SUMMARY_ENABLE = 8'h10;
  localparam logic [7:0] OFF_QUESTIONABLE_SUMMARY_COND = 8'h14;
  localparam logic [7:0] OFF_QUESTIONABLE_SUMMARY_PTR = 8'h18;
  localparam logic [7:0] OFF_QUESTIONABLE_SUMMARY_NTR = 8'h1c;
  localparam logic [7:0] OFF_QUESTIONABLE_SUMMARY_EVENT = 8'h20;
  localparam logic [7:0] OFF_QUESTIONABLE_SUMMARY_ENABLE = 8'h24;
  localparam logic [7:0] OFF_STB_QUERY = 8'h28;
  localparam logic [7:0] OFF_SRE = 8'h2c;
  localparam logic [7:0] OFF_CTRL = 8'h30;
  localparam logic [7:0] OFF_STB_POLL = 8'h34;
  // Field positions
  localparam int unsigned BIT_CONST_CURRENT = 10;
  localparam int unsigned BIT_CONST_VOLTAGE = 8;
  localparam int unsigned BIT_OVERCURRENT = 1;
  localparam int unsigned BIT_OVERTEMP = 4;
  localparam int unsigned STB_QUESTIONABLE_SUMMARY = 3;
  localparam int unsigned STB_RQS = 6;
  localparam int unsigned STB_OPERATION_SUMMARY = 7;
  localparam int unsigned CTRL_PRESET = 0;
  localparam int unsigned CTRL_CLEAR = 1;
  // Values after reset; preset loads only the PTR, NTR and ENABLE values
  localparam logic [15:0] PTR_RESET = 16'hffff;
  localparam logic [15:0] NTR_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] EVENT_RESET = 16'h0000;
  localparam logic [7:0] SRE_RESET = 8'h00;
  // One APB request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ser_apb_req_t;
  // One condition group's programmable state
  typedef struct packed {
    logic [15:0] ptr;
    logic [15:0] ntr;
    logic [15:0] event_bits;
    logic [15:0] enable;
  } ser_group_t;
endpackage

// file: core/ser_status_event.sv
// Purpose: Status event reporting with transition filters and service request
// Assumes: Single 100 MHz clock, synchronous active-high reset, APB slave
// Notes: Condition pins are asynchronous and pass two flip-flops first
//
// What this block does
// - Status byte readable by poll and query
// - Event read returns bits then clears
// - Request recurs once the event is read and the enabled condition retriggers
// - Constant current at bit 10 latches
// - Enabled operation events form operation summary
// - Mask weight 128 passes operation summary
// - Request flag set at status bit 6
// - Positive filters preset to all ones
// - Constant voltage at operation bit 8
// - Overcurrent bit 1, overtemperature bit 4
// - Mask 136 passes both summaries
// - Both filters set latch either edge
// - Falling edge after clear raises again
// - Request drives line, poll clears flag
// - Status byte query reads change nothing
// - Zero mask never raises request
`timescale 1ns/1ps
`default_nettype none
module ser_status_event (
  input wire logic CLK_SYS_IN,
  input wire logic SRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [15:0] OPERATION_SUMMARY_COND_IN,
  input wire logic [15:0] QUESTIONABLE_SUMMARY_COND_IN,
  output logic SRQ_OUT
);

  // Edge filter: a bit latches on a passed rising or falling edge
  function automatic logic [15:0] edge_hits(
    input logic [15:0] now_v,
    input logic [15:0] prev_v,
    input logic [15:0] ptr_v,
    input logic [15:0] ntr_v
  );
    edge_hits = (now_v & ~prev_v & ptr_v) | (~now_v & prev_v & ntr_v);
  endfunction

  // Summary: OR over event bits gated by enables
  function automatic logic summary_of(
    input logic [15:0] ev_v,
    input logic [15:0] en_v
  );
    summary_of = |(ev_v & en_v);
  endfunction

  ser_pkg::ser_apb_req_t req;
  ser_pkg::ser_group_t operation_summary_q, operation_summary_d, questionable_summary_q, questionable_summary_d;
  logic [15:0] operation_summary_s1_q, operation_summary_s2_q, operation_summary_prev_q;
  logic [15:0] questionable_summary_s1_q, questionable_summary_s2_q, questionable_summary_prev_q;
  logic [7:0] sre_q;
  logic rqs_q, mss_q;
  logic [31:0] prdata_q;
  logic slverr_q;
  logic [31:0] rdata;
  logic hit;

  assign req = '{psel: PSEL_IN, penable: PENABLE_IN, pwrite: PWRITE_IN,
                 paddr: PADDR_IN, pwdata: PWDATA_IN};

  // Bus phase decode
  wire setup_ph = req.psel & ~req.penable;
  wire done = req.psel & req.penable;
  wire wr_done = done & req.pwrite & ~slverr_q;
  wire rd_done = done & ~req.pwrite & ~slverr_q;
  wire [15:0] wlo = req.pwdata[15:0];

  // Register selects
  wire sel_optr = req.paddr == ser_pkg::OFF_OPERATION_SUMMARY_PTR;
  wire sel_ontr = req.paddr == ser_pkg::OFF_OPERATION_SUMMARY_NTR;
  wire sel_oev = req.paddr == ser_pkg::OFF_OPERATION_SUMMARY_EVENT;
  wire sel_oen = req.paddr == ser_pkg::OFF_OPERATION_SUMMARY_ENABLE;
  wire sel_qptr = req.paddr == ser_pkg::OFF_QUESTIONABLE_SUMMARY_PTR;
  wire sel_qntr = req.paddr == ser_pkg::OFF_QUESTIONABLE_SUMMARY_NTR;
  wire sel_qev = req.paddr == ser_pkg::OFF_QUESTIONABLE_SUMMARY_EVENT;
  wire sel_qen = req.paddr == ser_pkg::OFF_QUESTIONABLE_SUMMARY_ENABLE;
  wire sel_sre = req.paddr == ser_pkg::OFF_SRE;
  wire sel_ctrl = req.paddr == ser_pkg::OFF_CTRL;
  wire sel_poll = req.paddr == ser_pkg::OFF_STB_POLL;
  wire sel_query = req.paddr == ser_pkg::OFF_STB_QUERY;

  // Command strobes
  wire preset = wr_done & sel_ctrl & req.pwdata[ser_pkg::CTRL_PRESET];
  wire clear_all = wr_done & sel_ctrl & req.pwdata[ser_pkg::CTRL_CLEAR];
  wire rd_oev = rd_done & sel_oev;
  wire rd_qev = rd_done & sel_qev;
  wire poll_done = rd_done & sel_poll;

  // Named condition bits
  wire const_current_flag = operation_summary_s2_q[ser_pkg::BIT_CONST_CURRENT];
  wire const_voltage_flag = operation_summary_s2_q[ser_pkg::BIT_CONST_VOLTAGE];
  wire overcurrent_flag = questionable_summary_s2_q[ser_pkg::BIT_OVERCURRENT];
  wire overtemp_flag = questionable_summary_s2_q[ser_pkg::BIT_OVERTEMP];

  // Edges are judged against last cycle's synchronised value
  wire [15:0] operation_summary_new = edge_hits(operation_summary_s2_q, operation_summary_prev_q,
                                   operation_summary_q.ptr, operation_summary_q.ntr);
  wire [15:0] questionable_summary_new = edge_hits(questionable_summary_s2_q, questionable_summary_prev_q,
                                   questionable_summary_q.ptr, questionable_summary_q.ntr);

  // Summaries feed the status byte
  wire operation_summary = summary_of(operation_summary_q.event_bits, operation_summary_q.enable);
  wire questionable_summary = summary_of(questionable_summary_q.event_bits, questionable_summary_q.enable);

  // Status byte without bit 6, then the two views of bit 6
  wire [7:0] stb_base = {operation_summary, 3'h0,
                         questionable_summary, 3'h0};
  wire mss = |(stb_base & sre_q);
  wire [7:0] stb_poll = stb_base | ({7'h00, rqs_q} << ser_pkg::STB_RQS);
  wire [7:0] stb_query = stb_base | ({7'h00, mss} << ser_pkg::STB_RQS);
  wire rqs_set = mss & ~mss_q;

  // Read data selection
  always_comb
  begin
    rdata = 32'h00000000;
    hit = 1'b1;
    unique case (req.paddr)
      ser_pkg::OFF_OPERATION_SUMMARY_COND: rdata = {16'h0000, operation_summary_s2_q};
      ser_pkg::OFF_OPERATION_SUMMARY_PTR: rdata = {16'h0000, operation_summary_q.ptr};
      ser_pkg::OFF_OPERATION_SUMMARY_NTR: rdata = {16'h0000, operation_summary_q.ntr};
      ser_pkg::OFF_OPERATION_SUMMARY_EVENT: rdata = {16'h0000, operation_summary_q.event_bits};
      ser_pkg::OFF_OPERATION_SUMMARY_ENABLE: rdata = {16'h0000, operation_summary_q.enable};
      ser_pkg::OFF_QUESTIONABLE_SUMMARY_COND: rdata = {16'h0000, questionable_summary_s2_q};
      ser_pkg::OFF_QUESTIONABLE_SUMMARY_PTR: rdata = {16'h0000, questionable_summary_q.ptr};
      ser_pkg::OFF_QUESTIONABLE_SUMMARY_NTR: rdata = {16'h0000, questionable_summary_q.ntr};
      ser_pkg::OFF_QUESTIONABLE_SUMMARY_EVENT: rdata = {16'h0000, questionable_summary_q.event_bits};
      ser_pkg::OFF_QUESTIONABLE_SUMMARY_ENABLE: rdata = {16'h0000, questionable_summary_q.enable};
      ser_pkg::OFF_STB_QUERY: rdata = {24'h000000, stb_query};
      ser_pkg::OFF_SRE: rdata = {24'h000000, sre_q};
      ser_pkg::OFF_CTRL: rdata = 32'h00000000;
      ser_pkg::OFF_STB_POLL: rdata = {24'h000000, stb_poll};
      default: hit = 1'b0;
    endcase
  end

  // Operation group next state; a new event beats a read-clear
  always_comb
  begin
    operation_summary_d = operation_summary_q;
    if (wr_done & sel_optr)
      operation_summary_d.ptr = wlo;
    if (wr_done & sel_ontr)
      operation_summary_d.ntr = wlo;
    if (wr_done & sel_oen)
      operation_summary_d.enable = wlo;
    if (preset)
    begin
      operation_summary_d.ptr = ser_pkg::PTR_RESET;
      operation_summary_d.ntr = ser_pkg::NTR_RESET;
      operation_summary_d.enable = ser_pkg::ENABLE_RESET;
    end
    // Only bits that went out on the bus are cleared
    if (rd_oev)
      operation_summary_d.event_bits = operation_summary_q.event_bits & ~prdata_q[15:0];
    if (clear_all)
      operation_summary_d.event_bits = ser_pkg::EVENT_RESET;
    operation_summary_d.event_bits = operation_summary_d.event_bits | operation_summary_new;
  end

  // Questionable group next state, same scheme
  always_comb
  begin
    questionable_summary_d = questionable_summary_q;
    if (wr_done & sel_qptr)
      questionable_summary_d.ptr = wlo;
    if (wr_done & sel_qntr)
      questionable_summary_d.ntr = wlo;
    if (wr_done & sel_qen)
      questionable_summary_d.enable = wlo;
    if (preset)
    begin
      questionable_summary_d.ptr = ser_pkg::PTR_RESET;
      questionable_summary_d.ntr = ser_pkg::NTR_RESET;
      questionable_summary_d.enable = ser_pkg::ENABLE_RESET;
    end
    if (rd_qev)
      questionable_summary_d.event_bits = questionable_summary_q.event_bits & ~prdata_q[15:0];
    if (clear_all)
      questionable_summary_d.event_bits = ser_pkg::EVENT_RESET;
    questionable_summary_d.event_bits = questionable_summary_d.event_bits | questionable_summary_new;
  end

  // Condition synchronisers and previous-value registers
  always_ff @(posedge CLK_SYS_IN)
  begin
    operation_summary_s1_q <= OPERATION_SUMMARY_COND_IN;
    operation_summary_s2_q <= operation_summary_s1_q;
    questionable_summary_s1_q <= QUESTIONABLE_SUMMARY_COND_IN;
    questionable_summary_s2_q <= questionable_summary_s1_q;
    operation_summary_prev_q <= operation_summary_s2_q;
    questionable_summary_prev_q <= questionable_summary_s2_q;
  end

  // Group registers
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (SRST_IN)
    begin
      operation_summary_q <= '{ser_pkg::PTR_RESET, ser_pkg::NTR_RESET,
                  ser_pkg::EVENT_RESET, ser_pkg::ENABLE_RESET};
      questionable_summary_q <= '{ser_pkg::PTR_RESET, ser_pkg::NTR_RESET,
                  ser_pkg::EVENT_RESET, ser_pkg::ENABLE_RESET};
    end
    else
    begin
      operation_summary_q <= operation_summary_d;
      questionable_summary_q <= questionable_summary_d;
    end
  end

  // Service request mask
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (SRST_IN)
      sre_q <= ser_pkg::SRE_RESET;
    else if (wr_done & sel_sre)
      sre_q <= req.pwdata[7:0];
  end

  // Request flag: a new reason sets it, a poll clears only it; set wins
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (SRST_IN)
    begin
      rqs_q <= 1'b0;
      mss_q <= 1'b0;
    end
    else
    begin
      mss_q <= mss;
      rqs_q <= rqs_set | (rqs_q & ~poll_done);
    end
  end

  // Read data is captured in the setup cycle so the access cycle is zero-wait
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (SRST_IN)
    begin
      prdata_q <= 32'h00000000;
      slverr_q <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_q <= req.pwrite ? 32'h00000000 : rdata;
      slverr_q <= ~hit;
    end
  end

  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = done;
  assign PSLVERR_OUT = done & slverr_q;
  assign SRQ_OUT = rqs_q;

  // Checks
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (SRST_IN);

  sequence s_cc_rise;
    $rose(const_current_flag) && operation_summary_q.ptr[ser_pkg::BIT_CONST_CURRENT];
  endsequence

  sequence s_cc_fall;
    $fell(const_current_flag) && operation_summary_q.ntr[ser_pkg::BIT_CONST_CURRENT];
  endsequence

  a_cc_rise_latch: assert property (
    s_cc_rise |=> operation_summary_q.event_bits[ser_pkg::BIT_CONST_CURRENT])
    else $error("Rising constant current not latched");

  a_cc_fall_latch: assert property (
    s_cc_fall |=> operation_summary_q.event_bits[ser_pkg::BIT_CONST_CURRENT])
    else $error("Falling constant current not latched");

  a_event_read_clears: assert property (
    rd_oev && !clear_all && operation_summary_new == 16'h0000
    |=> (operation_summary_q.event_bits & $past(prdata_q)) == 16'h0000)
    else $error("Operation event read did not clear");

  a_operation_summary_summary_bit: assert property (
    operation_summary_q.event_bits[ser_pkg::BIT_CONST_CURRENT]
    && operation_summary_q.enable[ser_pkg::BIT_CONST_CURRENT]
    |-> stb_base[ser_pkg::STB_OPERATION_SUMMARY])
    else $error("Operation summary missing");

  a_request_raised: assert property (
    $rose(mss) |=> rqs_q ##0 SRQ_OUT ##0 stb_poll[ser_pkg::STB_RQS])
    else $error("Request flag not raised");

  a_poll_clears_rqs: assert property (
    poll_done && !rqs_set |=> !SRQ_OUT && $stable(sre_q))
    else $error("Poll did not clear request flag");

  a_query_no_change: assert property (
    rd_done && sel_query && !rqs_set && !poll_done
    |=> $stable(rqs_q) && $stable(sre_q))
    else $error("Status query disturbed state");

  a_zero_mask_quiet: assert property (
    sre_q == 8'h00 && !rqs_q |=> !SRQ_OUT)
    else $error("Request with zero mask");

  a_preset_ptr_ones: assert property (
    preset |=> operation_summary_q.ptr == 16'hffff && questionable_summary_q.ptr == 16'hffff
    && operation_summary_q.enable == 16'h0000)
    else $error("Preset did not restore filters");

  // Named condition bits must reach their own event positions
  a_cv_rise_latch: assert property (
    $rose(const_voltage_flag) && operation_summary_q.ptr[ser_pkg::BIT_CONST_VOLTAGE]
    |=> operation_summary_q.event_bits[ser_pkg::BIT_CONST_VOLTAGE])
    else $error("Rising constant voltage not latched");

  a_oc_rise_latch: assert property (
    $rose(overcurrent_flag) && questionable_summary_q.ptr[ser_pkg::BIT_OVERCURRENT]
    |=> questionable_summary_q.event_bits[ser_pkg::BIT_OVERCURRENT])
    else $error("Rising overcurrent not latched");

  a_ot_rise_latch: assert property (
    $rose(overtemp_flag) && questionable_summary_q.ptr[ser_pkg::BIT_OVERTEMP]
    |=> questionable_summary_q.event_bits[ser_pkg::BIT_OVERTEMP])
    else $error("Rising overtemperature not latched");

  // Either summary alone must be enough once both are unmasked
  a_mask_both_pass: assert property (
    sre_q == 8'h88 && (operation_summary || questionable_summary)
    |-> stb_query[ser_pkg::STB_RQS])
    else $error("Summary with mask 136 gave no request reason");

endmodule
`default_nettype wire

// file: verif/ser_host_model.sv
// Purpose: Remote controller model issuing APB reads and writes
// Assumes: Zero or more wait states, answer seen when pready is high
// Notes: Signals change only by non-blocking assignment after an edge
`timescale 1ns/1ps
`default_nettype none
module ser_host_model (
  input wire logic clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // One transfer; request held until pready is seen, the bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: verif/ser_status_event_tb_top.sv
// Purpose: Self-checking bench for the status event reporting block
// Assumes: Zero wait APB, conditions reach events three cycles after change
// Notes: Expected events come from an integer edge model
`timescale 1ns/1ps
`default_nettype none
module ser_status_event_tb_top;
  logic clk, srst, psel, pen, pwr, rdy, err, srq, e;
  logic [7:0] pa;
  logic [31:0] pwd, prd, rv;
  logic [15:0] oc, qc;
  logic [31:0] seed = 32'h48adc083;
  int error_cnt = 0;
  int samples_checked = 0;
  ser_status_event u_dut (.CLK_SYS_IN(clk), .SRST_IN(srst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd),
    .PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(err),
    .OPERATION_SUMMARY_COND_IN(oc), .QUESTIONABLE_SUMMARY_COND_IN(qc), .SRQ_OUT(srq));
  ser_host_model u_host (.clk(clk), .pready(rdy), .pslverr(err), .prdata(prd),
    .psel(psel), .penable(pen), .pwrite(pwr), .paddr(pa), .pwdata(pwd));
  // Edge model: rising edges pass the positive filter, falling the negative
  function automatic int mdl(int prv, int now, int ptr, int ntr);
    return ((~prv & now & ptr) | (prv & ~now & ntr)) & 32'hffff;
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    u_host.xfer(1'b0, a, 32'h0, rv, e);
    chk(rv, x);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rv, e);
  endtask
  // Sync, edge, summary and request stages all settle inside this span
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask
  task automatic results();
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard, far beyond the roughly 165 cycles the tests need
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    results();
  end
  initial
  begin
    srst = 1'b1;
    oc = 16'h0;
    qc = 16'h0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    rd(ser_pkg::OFF_OPERATION_SUMMARY_PTR, 32'hffff);
    rd(ser_pkg::OFF_QUESTIONABLE_SUMMARY_NTR, 32'h0);
    rd(ser_pkg::OFF_SRE, 32'h0);
    rd(8'h3c, 32'h0);
    chk(e, 1'b1);
    repeat (4)
    begin
      seed = xs(seed);
      wr(ser_pkg::OFF_QUESTIONABLE_SUMMARY_ENABLE, seed);
      rd(ser_pkg::OFF_QUESTIONABLE_SUMMARY_ENABLE, seed & 32'hffff);
    end
    wr(ser_pkg::OFF_QUESTIONABLE_SUMMARY_ENABLE, 32'h0);
    $display("reset and access test done");
    wr(ser_pkg::OFF_OPERATION_SUMMARY_ENABLE, 32'd1024);
    wr(ser_pkg::OFF_SRE, 32'd128);
    oc <= 16'h0400;
    settle();
    chk(srq, 1'b1);
    rd(ser_pkg::OFF_STB_QUERY, 32'hc0);
    rd(ser_pkg::OFF_STB_QUERY, 32'hc0);
    rd(ser_pkg::OFF_STB_POLL, 32'hc0);
    rd(ser_pkg::OFF_STB_POLL, 32'h80);
    rd(ser_pkg::OFF_OPERATION_SUMMARY_EVENT, mdl(0, 1024, 65535, 0));
    rd(ser_pkg::OFF_OPERATION_SUMMARY_EVENT, 32'h0);
    rd(ser_pkg::OFF_STB_QUERY, 32'h0);
    chk(srq, 1'b0);
    $display("rising edge test done");
    wr(ser_pkg::OFF_OPERATION_SUMMARY_NTR, 32'd1024);
    oc <= 16'h0;
    settle();
    chk(srq, 1'b1);
    rd(ser_pkg::OFF_OPERATION_SUMMARY_EVENT, mdl(1024, 0, 65535, 1024));
    rd(ser_pkg::OFF_STB_POLL, 32'h40);
    $display("falling edge test done");
    wr(ser_pkg::OFF_OPERATION_SUMMARY_ENABLE, 32'd1280);
    wr(ser_pkg::OFF_QUESTIONABLE_SUMMARY_PTR, 32'd18);
    wr(ser_pkg::OFF_QUESTIONABLE_SUMMARY_ENABLE, 32'd18);
    wr(ser_pkg::OFF_SRE, 32'd136);
    oc <= 16'h0100;
    qc <= 16'h0012;
    settle();
    rd(ser_pkg::OFF_STB_QUERY, 32'hc8);
    rd(ser_pkg::OFF_OPERATION_SUMMARY_EVENT, mdl(0, 256, 65535, 1024));
    rd(ser_pkg::OFF_QUESTIONABLE_SUMMARY_EVENT, mdl(0, 18, 18, 0));
    rd(ser_pkg::OFF_STB_POLL, 32'h40);
    $display("both groups test done");
    wr(ser_pkg::OFF_SRE, 32'h0);
    oc <= 16'h0500;
    settle();
    chk(srq, 1'b0);
    rd(ser_pkg::OFF_STB_QUERY, 32'h80);
    rd(ser_pkg::OFF_OPERATION_SUMMARY_EVENT, mdl(256, 1280, 65535, 1024));
    $display("zero mask test done");
    wr(ser_pkg::OFF_OPERATION_SUMMARY_PTR, 32'h0);
    wr(ser_pkg::OFF_CTRL, 32'h1);
    rd(ser_pkg::OFF_OPERATION_SUMMARY_PTR, 32'hffff);
    rd(ser_pkg::OFF_OPERATION_SUMMARY_NTR, 32'h0);
    rd(ser_pkg::OFF_OPERATION_SUMMARY_ENABLE, 32'h0);
    $display("preset test done");
    results();
  end
endmodule
`default_nettype wire
